//--- hw/bcm_break_matcher.sv
// Notes on behaviour
// - Initiator field: 00 none, 01 processor, 10 DMA, 11 either.
// - Fetch/data field: 00 none, 01 fetch, 10 data, 11 both.
// - Direction field: 00 none, 01 read, 10 write, 11 both.
// - Size field: 00 any size, 01 byte, 10 word, 11 longword only.
// - Any of initiator, fetch/data or direction at 00 blocks every break.
// - Every fetch counts as word size; software keeps low size bit zero.
// - Compared size is operand size, never the addressed region's bus width.
// - Unused upper register bits read zero; software writes zeros.
// - Registers clear on reset and module standby, keep through software standby.
// - Trigger width: 00 one clock, 01 four, 10 eight, 11 sixteen clocks.
// - Interrupt request only while the interrupt-disable bit is zero.
// - A match raises the interrupt request and starts the trigger pulse together; an overrun fetch match only starts the trigger.
// - Both instructions of a dual fetch are matched on their own addresses.
// - Fetch break is taken before execution; saved counter is matched address.
// - Delay-slot or blocked fetch breaks are deferred by the processor.
// - Data break point is imprecise; counter is next instruction's address.
// - Break address is two halves: upper bits 31-16, lower bits 15-0.
// - A mask bit at one excludes that address bit from the compare.
// - Trigger stays low through recurring matches, full width after the last.
`timescale 1ns/100ps
`default_nettype none
`include "bcm_consts.svh"

module bcm_break_matcher (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Module standby, clears the configuration.
    input wire logic module_standby,
    // Avalon-MM register slave, byte addressed.
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Monitored processor and DMA bus cycle.
    input wire logic mon_valid,
    input wire logic [31:0] mon_addr,
    input wire logic mon_is_dma,
    input wire logic mon_is_fetch,
    input wire logic mon_dual_fetch,
    input wire logic mon_overrun,
    input wire logic mon_is_write,
    input wire logic [1:0] mon_size,
    // Break request to the interrupt controller.
    output logic break_irq_req,
    input wire logic break_irq_ack,
    output logic [31:0] break_pc_addr,
    output logic break_was_fetch,
    output logic break_was_second,
    // Trigger pin, active low.
    output logic match_trigger_out_n
);

    bcm_pkg::bcm_state_t st_reg;
    bcm_pkg::bcm_state_t st_next;

    logic [31:0] brk_addr;
    logic [31:0] brk_mask;
    logic init_ok;
    logic fd_ok;
    logic dir_ok;
    logic size_ok;
    logic [1:0] eff_size;
    logic qual_ok;
    logic hit_first;
    logic hit_second;
    logic match;
    logic irq_match;
    logic [4:0] pw_cycles;
    logic [7:0] reg_idx;
    logic bus_req;
    logic [15:0] wr_half;

    assign brk_addr = {st_reg.addr_hi, st_reg.addr_lo};
    assign brk_mask = {st_reg.mask_hi, st_reg.mask_lo};

    // Qualifier decode; each two-bit field at 00 qualifies nothing.
    always_comb begin
        case (st_reg.qual[`BCM_QUAL_INIT_HI:`BCM_QUAL_INIT_LO])
            2'h1: init_ok = !mon_is_dma;
            2'h2: init_ok = mon_is_dma;
            2'h3: init_ok = 1'b1;
            default: init_ok = 1'b0;
        endcase
        case (st_reg.qual[`BCM_QUAL_FD_HI:`BCM_QUAL_FD_LO])
            2'h1: fd_ok = mon_is_fetch;
            2'h2: fd_ok = !mon_is_fetch;
            2'h3: fd_ok = 1'b1;
            default: fd_ok = 1'b0;
        endcase
        case (st_reg.qual[`BCM_QUAL_DIR_HI:`BCM_QUAL_DIR_LO])
            2'h1: dir_ok = !mon_is_write;
            2'h2: dir_ok = mon_is_write;
            2'h3: dir_ok = 1'b1;
            default: dir_ok = 1'b0;
        endcase
    end

    // Operand size, not bus width; a fetch always counts as a word.
    assign eff_size = mon_is_fetch ? `BCM_SIZE_WORD : mon_size;
    assign size_ok = (st_reg.qual[`BCM_QUAL_SIZE_HI:`BCM_QUAL_SIZE_LO] == 2'h0) ||
                     (st_reg.qual[`BCM_QUAL_SIZE_HI:`BCM_QUAL_SIZE_LO] == eff_size);
    assign qual_ok = init_ok && fd_ok && dir_ok && size_ok;

    // Masked compare; the second half of a dual fetch has its own start address.
    assign hit_first = ((mon_addr ^ brk_addr) & ~brk_mask) == 32'h0000_0000;
    assign hit_second = mon_is_fetch && mon_dual_fetch &&
                        (((mon_addr + `BCM_DUAL_STEP) ^ brk_addr) & ~brk_mask) == 32'h0000_0000;
    assign match = mon_valid && qual_ok && (hit_first || hit_second);

    // Overrun fetches drive the trigger but never ask for an interrupt.
    assign irq_match = match && !(mon_is_fetch && mon_overrun) && !st_reg.ctrl[`BCM_CTRL_IRQ_DIS];

    // Pulse width select.
    always_comb begin
        case (st_reg.ctrl[`BCM_CTRL_PW_HI:`BCM_CTRL_PW_LO])
            2'h1: pw_cycles = `BCM_PW_DIV4;
            2'h2: pw_cycles = `BCM_PW_DIV8;
            2'h3: pw_cycles = `BCM_PW_DIV16;
            default: pw_cycles = `BCM_PW_DIV1;
        endcase
    end

    assign reg_idx = {2'h0, avs_address[7:2]};
    assign bus_req = avs_read || avs_write;
    assign wr_half = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
                      avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};

    // Next state: register access, trigger counter, interrupt request.
    always_comb begin
        st_next = st_reg;
        // One wait state, then the answer; read data is registered at that edge.
        st_next.ack = bus_req && !st_reg.ack;
        if (bus_req && !st_reg.ack) begin
            st_next.rdata = 32'h0000_0000;
            if (avs_read) begin
                case (reg_idx)
                    `BCM_IDX_ADDR_HI: st_next.rdata = {16'h0000, st_reg.addr_hi};
                    `BCM_IDX_ADDR_LO: st_next.rdata = {16'h0000, st_reg.addr_lo};
                    `BCM_IDX_MASK_HI: st_next.rdata = {16'h0000, st_reg.mask_hi};
                    `BCM_IDX_MASK_LO: st_next.rdata = {16'h0000, st_reg.mask_lo};
                    `BCM_IDX_QUAL: st_next.rdata = {24'h00_0000, st_reg.qual};
                    `BCM_IDX_CTRL: st_next.rdata = {29'h0000_0000, st_reg.ctrl};
                    `BCM_IDX_STATUS: st_next.rdata = {28'h000_0000, st_reg.hit_second,
                                                      st_reg.hit_fetch, !st_reg.trig_n, st_reg.irq};
                    default: st_next.rdata = 32'h0000_0000;
                endcase
            end
        end
        // Writes take effect on the edge that samples waitrequest low, one clock after the wait state ends.
        if (avs_write && st_reg.ack) begin
            case (reg_idx)
                `BCM_IDX_ADDR_HI: st_next.addr_hi = wr_half;
                `BCM_IDX_ADDR_LO: st_next.addr_lo = wr_half;
                `BCM_IDX_MASK_HI: st_next.mask_hi = wr_half;
                `BCM_IDX_MASK_LO: st_next.mask_lo = wr_half;
                `BCM_IDX_QUAL: st_next.qual = wr_half[`BCM_QUAL_BITS-1:0];
                `BCM_IDX_CTRL: st_next.ctrl = wr_half[`BCM_CTRL_BITS-1:0];
                default: st_next.qual = st_reg.qual;
            endcase
        end
        // Trigger restarts a full width on each match.
        if (match) begin
            st_next.trig_cnt = pw_cycles;
        end else if (st_reg.trig_cnt != 5'h00) begin
            st_next.trig_cnt = st_reg.trig_cnt - 5'h01;
        end
        st_next.trig_n = !(match || st_reg.trig_cnt > 5'h01);
        // Request stays pending until acknowledged; a new match wins over the ack.
        if (irq_match) begin
            st_next.irq = 1'b1;
            st_next.hit_fetch = mon_is_fetch;
            st_next.hit_second = !hit_first;
            st_next.hit_addr = hit_first ? mon_addr : mon_addr + `BCM_DUAL_STEP;
        end else if (break_irq_ack) begin
            st_next.irq = 1'b0;
        end
        // Module standby clears configuration; software standby keeps it.
        if (module_standby) begin
            st_next.addr_hi = `BCM_RESET_HALF;
            st_next.addr_lo = `BCM_RESET_HALF;
            st_next.mask_hi = `BCM_RESET_HALF;
            st_next.mask_lo = `BCM_RESET_HALF;
            st_next.qual = `BCM_RESET_QUAL;
            st_next.ctrl = `BCM_RESET_CTRL;
        end
    end

    // All state in one register, cleared by the asynchronous reset except trig_n, which resets high.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
            st_reg.trig_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs; only waitrequest is combinational.
    assign avs_waitrequest = bus_req && !st_reg.ack;
    assign avs_readdata = st_reg.rdata;
    assign break_irq_req = st_reg.irq;
    assign break_pc_addr = st_reg.hit_addr;
    assign break_was_fetch = st_reg.hit_fetch;
    assign break_was_second = st_reg.hit_second;
    assign match_trigger_out_n = st_reg.trig_n;

    // Helper: cycles the trigger has stayed low since the most recent match.
    // Counting from the match rather than from the falling edge lets a stretched pulse pass the bound check.
    logic [4:0] low_run;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            low_run <= 5'h00;
        end else begin
            low_run <= (match || st_reg.trig_n) ? 5'h00 : low_run + 5'h01;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    init_zero_a: assert property (st_reg.qual[7:6] == 2'h0 |-> !match)
        else $error("match with initiator field clear");
    fd_zero_a: assert property (st_reg.qual[5:4] == 2'h0 |-> !match)
        else $error("match with fetch data field clear");
    dir_zero_a: assert property (st_reg.qual[3:2] == 2'h0 |=> match_trigger_out_n || $past(st_reg.trig_cnt) != 5'h00)
        else $error("trigger started with direction field clear");
    fetch_word_a: assert property (mon_valid && mon_is_fetch && st_reg.qual[1:0] == 2'h1 |-> !match)
        else $error("fetch matched as byte access");
    irq_disable_a: assert property (st_reg.ctrl[0] && !break_irq_req |=> !break_irq_req)
        else $error("interrupt raised while disabled");
    match_both_a: assert property (irq_match |=> break_irq_req && !match_trigger_out_n)
        else $error("match did not raise both outputs");
    pending_hold_a: assert property (break_irq_req && !break_irq_ack |=> break_irq_req)
        else $error("pending request dropped without ack");
    width_one_a: assert property (match && st_reg.ctrl[2:1] == 2'h0 ##1 !match |=> match_trigger_out_n)
        else $error("single clock pulse too long");
    width_four_a: assert property (match && st_reg.ctrl[2:1] == 2'h1 ##1 !match [*4] |-> ##1 match_trigger_out_n)
        else $error("four clock pulse too long");
    pulse_bound_a: assert property (low_run == 5'h10 |-> match_trigger_out_n)
        else $error("trigger low beyond sixteen clocks without match");
    rd_reserved_a: assert property (avs_read && !avs_waitrequest && avs_address[7:2] == 6'h0a |-> avs_readdata[31:3] == 29'h0)
        else $error("reserved control bits read nonzero");
    standby_clr_a: assert property (module_standby && !(avs_write && st_reg.ack) |=> st_reg.qual == 8'h00 && st_reg.ctrl == 3'h0)
        else $error("standby did not clear registers");
    dual_second_a: assert property (irq_match && !hit_first |=> break_was_second && break_pc_addr == $past(mon_addr) + 32'h2)
        else $error("second fetch address not recorded");
    answer_one_a: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer later than one wait state");

    fetch_break_c: cover property (irq_match && mon_is_fetch);
    dma_break_c: cover property (irq_match && mon_is_dma);
    retrigger_c: cover property (match ##2 match);
    overrun_c: cover property (match && mon_is_fetch && mon_overrun);

endmodule : bcm_break_matcher
`default_nettype wire

//--- hw/bcm_consts.svh
`ifndef BCM_CONSTS_SVH
`define BCM_CONSTS_SVH

// Register indices as printed; the byte address is four times the index.
`define BCM_IDX_ADDR_HI 8'h00
`define BCM_IDX_ADDR_LO 8'h02
`define BCM_IDX_MASK_HI 8'h04
`define BCM_IDX_MASK_LO 8'h06
`define BCM_IDX_QUAL 8'h08
`define BCM_IDX_CTRL 8'h0a
`define BCM_IDX_STATUS 8'h0c

// Field positions in the cycle-qualifier register.
`define BCM_QUAL_INIT_HI 7
`define BCM_QUAL_INIT_LO 6
`define BCM_QUAL_FD_HI 5
`define BCM_QUAL_FD_LO 4
`define BCM_QUAL_DIR_HI 3
`define BCM_QUAL_DIR_LO 2
`define BCM_QUAL_SIZE_HI 1
`define BCM_QUAL_SIZE_LO 0
`define BCM_QUAL_BITS 8

// Field positions in the control register.
`define BCM_CTRL_PW_HI 2
`define BCM_CTRL_PW_LO 1
`define BCM_CTRL_IRQ_DIS 0
`define BCM_CTRL_BITS 3

// Reset values.
`define BCM_RESET_HALF 16'h0000
`define BCM_RESET_QUAL 8'h00
`define BCM_RESET_CTRL 3'h0

// Trigger pulse widths in core clock cycles.
`define BCM_PW_DIV1 5'h01
`define BCM_PW_DIV4 5'h04
`define BCM_PW_DIV8 5'h08
`define BCM_PW_DIV16 5'h10

// Operand size codes on the monitored bus.
`define BCM_SIZE_BYTE 2'h1
`define BCM_SIZE_WORD 2'h2
`define BCM_SIZE_LONG 2'h3

// Offset of the second instruction in a dual fetch.
`define BCM_DUAL_STEP 32'h0000_0002

`endif

//--- hw/bcm_pkg.sv
`include "bcm_consts.svh"

package bcm_pkg;

    // Whole state of the break matcher.
    typedef struct packed {
        logic [15:0] addr_hi;
        logic [15:0] addr_lo;
        logic [15:0] mask_hi;
        logic [15:0] mask_lo;
        logic [`BCM_QUAL_BITS-1:0] qual;
        logic [`BCM_CTRL_BITS-1:0] ctrl;
        logic ack;
        logic [31:0] rdata;
        logic [4:0] trig_cnt;
        logic trig_n;
        logic irq;
        logic hit_fetch;
        logic hit_second;
        logic [31:0] hit_addr;
    } bcm_state_t;

endpackage : bcm_pkg

//--- test/bcm_interrupt_controller_model.sv
`timescale 1ns/100ps
`default_nettype none
module bcm_interrupt_controller_model (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Break request and its acknowledge.
    input wire logic break_irq_req,
    output logic break_irq_ack,
    // Processor mask level and answer latency chosen by the bench.
    input wire logic [3:0] interrupt_mask_level,
    input wire logic [1:0] ack_delay
);
    logic [1:0] wait_cnt;
    // The break request ranks at level 15, so a mask level of 15 leaves it pending until lowered.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            break_irq_ack <= 1'b0;
            wait_cnt <= 2'h0;
        end else begin
            break_irq_ack <= 1'b0;
            if (break_irq_req && !break_irq_ack && interrupt_mask_level <= 4'he) begin
                if (wait_cnt == ack_delay) begin
                    break_irq_ack <= 1'b1;
                    wait_cnt <= 2'h0;
                end else begin
                    wait_cnt <= wait_cnt + 2'h1;
                end
            end else begin
                wait_cnt <= 2'h0;
            end
        end
    end
endmodule : bcm_interrupt_controller_model
`default_nettype wire

//--- test/bcm_break_matcher_tb.sv
`timescale 1ns/100ps
`default_nettype none
module bcm_break_matcher_tb;
    // Design connections; every design input the bench drives is given a value at time zero.
    logic core_clk = 1'b0, reset_n = 1'b0, module_standby = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, mon_addr = 32'h0, avs_readdata, break_pc_addr;
    logic [3:0] avs_byteenable = 4'h3, interrupt_mask_level = 4'h0;
    logic mon_valid = 1'b0, mon_is_dma = 1'b0, mon_is_fetch = 1'b0, mon_dual_fetch = 1'b0, mon_overrun = 1'b0;
    logic mon_is_write = 1'b0, avs_waitrequest, break_irq_req, break_irq_ack, break_was_fetch, break_was_second;
    logic match_trigger_out_n;
    logic [1:0] mon_size = 2'h2, ack_delay = 2'h0;
    // Bench state: expectations, counters and the programmed break condition.
    logic [33:0] rd_q[$], tw_q[$], pc_q[$];
    logic [33:0] e;
    logic [7:0] cfg_q;
    logic [2:0] cfg_ctl;
    logic [31:0] cfg_bar, cfg_msk;
    int mismatches = 0, n_checks = 0, cycles = 0, low_cnt = 0, seed = 32'hbd3f;
    logic irq_seen = 1'b0;

    bcm_break_matcher i_dut (.core_clk, .reset_n, .module_standby, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .mon_valid, .mon_addr, .mon_is_dma,
        .mon_is_fetch, .mon_dual_fetch, .mon_overrun, .mon_is_write, .mon_size, .break_irq_req, .break_irq_ack,
        .break_pc_addr, .break_was_fetch, .break_was_second, .match_trigger_out_n);
    bcm_interrupt_controller_model i_interrupt_controller (.core_clk, .reset_n, .break_irq_req, .break_irq_ack, .interrupt_mask_level, .ack_delay);

    // Clock at 40 MHz.
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // One Avalon transfer; the request stands until the rising edge that samples waitrequest low.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [15:0] x);
        rd_q.push_back({18'h0, x});
        bus(1'b0, a, 16'h0000);
    endtask : rd

    task automatic setup(input logic [7:0] q, input logic [2:0] c, input logic [31:0] b, input logic [31:0] m);
        cfg_q = q;
        cfg_ctl = c;
        cfg_bar = b;
        cfg_msk = m;
        bus(1'b1, 8'h00, b[31:16]);
        bus(1'b1, 8'h08, b[15:0]);
        bus(1'b1, 8'h10, m[31:16]);
        bus(1'b1, 8'h18, m[15:0]);
        bus(1'b1, 8'h20, {8'h00, q});
        bus(1'b1, 8'h28, {13'h0, c});
    endtask : setup

    // A fetch always counts as word size, whatever the operand size lines show.
    function automatic logic hit(input logic [31:0] a, input logic f, d, w, input logic [1:0] s);
        logic [1:0] es;
        es = f ? 2'h2 : s;
        return (d ? cfg_q[7] : cfg_q[6]) && (f ? cfg_q[4] : cfg_q[5]) && (w ? cfg_q[3] : cfg_q[2])
            && (cfg_q[1:0] == 2'h0 || cfg_q[1:0] == es) && (((a ^ cfg_bar) & ~cfg_msk) == 32'h0);
    endfunction : hit

    // One monitored bus cycle; the released address shows its inverse so stale values never match by luck.
    task automatic cyc(input logic [31:0] a, input logic f, d, w, dual, ovr, input logic [1:0] s);
        mon_valid <= 1'b1;
        mon_addr <= a;
        {mon_is_fetch, mon_is_dma, mon_is_write, mon_dual_fetch, mon_overrun, mon_size} <= {f, d, w, dual, ovr, s};
        @(posedge core_clk);
        mon_valid <= 1'b0;
        mon_addr <= ~a;
        @(posedge core_clk);
    endtask : cyc

    task automatic expect_cyc(input logic [31:0] a, input logic f, d, w, dual, ovr, input logic [1:0] s);
        logic m1, m2;
        m1 = hit(a, f, d, w, s);
        m2 = f && dual && hit(a + 32'h2, f, d, w, s);
        if (m1 || m2) begin
            tw_q.push_back(34'h1 << ((cfg_ctl[2:1] == 2'h0) ? 0 : cfg_ctl[2:1] + 1));
            if (!cfg_ctl[0] && !ovr) pc_q.push_back({f, !m1, m1 ? a : a + 32'h2});
        end
        cyc(a, f, d, w, dual, ovr, s);
    endtask : expect_cyc

    // Results are sampled mid-cycle, where every registered output has settled.
    always @(negedge core_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            e = (rd_q.size() != 0) ? rd_q.pop_front() : 'x;
            chk({2'h0, avs_readdata}, e, "read data");
        end
        if (match_trigger_out_n === 1'b0) begin
            low_cnt++;
        end else if (low_cnt != 0) begin
            e = (tw_q.size() != 0) ? tw_q.pop_front() : 'x;
            chk(34'(low_cnt), e, "trigger width");
            low_cnt = 0;
        end
        if (break_irq_req === 1'b1 && !irq_seen) begin
            e = (pc_q.size() != 0) ? pc_q.pop_front() : 'x;
            chk({break_was_fetch, break_was_second, break_pc_addr}, e, "break request");
        end
        irq_seen = (break_irq_req === 1'b1);
    end

    // The ceiling is about two and a half times the length of the planned run.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            test_done();
        end
    end

    initial begin
        logic [31:0] r, r2, a;
        logic f, dual;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd(8'h20, 16'h0000);
        rd(8'h28, 16'h0000);
        bus(1'b1, 8'h20, 16'hffff);
        rd(8'h20, 16'h00ff);
        bus(1'b1, 8'h28, 16'hffff);
        rd(8'h28, 16'h0007);
        bus(1'b1, 8'h00, 16'h5a3c);
        rd(8'h00, 16'h5a3c);
        rd(8'h3c, 16'h0000);
        module_standby <= 1'b1;
        @(posedge core_clk);
        module_standby <= 1'b0;
        rd(8'h20, 16'h0000);
        rd(8'h00, 16'h0000);
        $display("register test done");
        // Random conditions against random cycles; half the runs open all three qualifier fields.
        for (int i = 0; i < 400; i++) begin
            r = $random(seed);
            r2 = $random(seed);
            setup(r[7:0] | (r[29] ? 8'hfc : 8'h00), r[10:8], $random(seed), $random(seed) & $random(seed) & r2);
            f = r[11];
            dual = f & r[12];
            a = cfg_bar ^ ($random(seed) & cfg_msk);
            if (r[17] & r[18]) a = a ^ (32'h1 << r[23:19]);
            if (dual & r[24]) a = cfg_bar - 32'h2;
            ack_delay <= r[26:25];
            expect_cyc(a, f, !f & r[15], !f & r[16], dual, f & r[13] & r[14], (r[28:27] == 2'h0) ? 2'h2 : r[28:27]);
            repeat (20) @(posedge core_clk);
        end
        $display("random match test done");
        // A second match inside the pulse stretches it to the full width after the later match.
        setup(8'hfc, 3'h3, 32'h0000_1000, 32'h0);
        tw_q.push_back(34'd6);
        cyc(32'h1000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h3);
        cyc(32'h1000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h3);
        repeat (20) @(posedge core_clk);
        $display("retrigger test done");
        interrupt_mask_level <= 4'hf;
        setup(8'h54, 3'h0, 32'h0000_0404, 32'h0);
        expect_cyc(32'h0404, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2);
        repeat (20) @(posedge core_clk);
        chk({33'h0, break_irq_req}, 34'h1, "request held pending");
        rd(8'h30, 16'h0005);
        interrupt_mask_level <= 4'he;
        repeat (8) @(posedge core_clk);
        chk({33'h0, break_irq_req}, 34'h0, "request accepted");
        chk(34'(rd_q.size() + tw_q.size() + pc_q.size()), 34'h0, "results left over");
        $display("pending test done");
        test_done();
    end
endmodule : bcm_break_matcher_tb
`default_nettype wire
